// ### ecm_capture_unit.v
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`include "ecm_consts.vh"
// Functional notes
// - result byte pair and control register readable/writable
// - capture and compare use first timer
// - mode field selects capture edge and prescale
// - bits five-four hold duty LSbs only
// - software compare match sets flag only
// - special trigger flag, timer reset, conversion start
// - tristate bit two drives pin, resets high
// - selected event copies timer into result
// - capture sets flag; only software clears
// - new capture overwrites unread result
// - pin data write may cause capture
// - mode change may raise spurious flag
// - prescaler cleared when off or not capturing
// - prescale-to-prescale change keeps counter
module ecm_capture_unit #(
  parameter TW = 16
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire capture_pin_in,
  output reg capture_pin_out,
  output reg capture_pin_oe,
  input wire adc_enabled,
  output reg adc_start,
  output reg irq
);

  // ==========================================================
  // bus access
  // ==========================================================
  // one wait cycle: request taken on the first edge it is held
  reg ack_q;
  wire req = (avs_read | avs_write) & ~ack_q;
  wire wr = avs_write & req;
  wire [7:0] idx = avs_address[9:2];
  wire [7:0] wd = avs_writedata[7:0];
  wire wr_mode = wr & (idx == `ECM_IDX_MODE);
  wire wr_tris = wr & (idx == `ECM_IDX_TRIS);
  wire wr_resl = wr & (idx == `ECM_IDX_RESL);
  wire wr_resh = wr & (idx == `ECM_IDX_RESH);
  wire wr_tmrl = wr & (idx == `ECM_IDX_TMRL);
  wire wr_tmrh = wr & (idx == `ECM_IDX_TMRH);
  wire wr_tctl = wr & (idx == `ECM_IDX_TCTL);
  wire wr_stat = wr & (idx == `ECM_IDX_STAT);
  wire wr_mask = wr & (idx == `ECM_IDX_MASK);
  wire wr_pin = wr & (idx == `ECM_IDX_PIN);

  reg [7:0] mode_q;
  reg [7:0] tris_q;
  reg [TW-1:0] res_q;
  reg [TW-1:0] tmr_q;
  reg tmr_on_q;
  reg [7:0] stat_q;
  reg [7:0] mask_q;
  reg pin_data_q;
  reg [3:0] ps_q;
  reg sync1_q;
  reg sync2_q;
  reg pin_prev_q;

  wire [3:0] mfield = mode_q[3:0];
  wire cap_mode = (mfield[3:2] == 2'b01);
  wire spec_mode = (mfield == `ECM_MODE_CMP_SPEC);
  wire cmp_mode = (mfield == `ECM_MODE_CMP_SWI) | spec_mode;

  // ==========================================================
  // pin path
  // ==========================================================
  // while driven, the pad reflects the data bit so a software write can capture
  wire pin_drv = ~tris_q[`ECM_TRIS_PIN_BIT];
  wire pin_level = sync2_q;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      sync1_q <= capture_pin_in;
      sync2_q <= sync1_q;
      pin_prev_q <= pin_level;
    end
  end

  wire rise = pin_level & ~pin_prev_q;
  wire fall = ~pin_level & pin_prev_q;

  // ==========================================================
  // capture event and prescaler
  // ==========================================================
  reg evt;
  always @* begin
    case (mfield)
      `ECM_MODE_CAP_FALL: evt = fall;
      `ECM_MODE_CAP_RISE: evt = rise;
      `ECM_MODE_CAP_4: evt = rise & ({2'h0, ps_q[1:0]} == `ECM_PS_MAX4);
      `ECM_MODE_CAP_16: evt = rise & (ps_q == `ECM_PS_MAX16);
      default: evt = 1'b0;
    endcase
  end

  // counter kept across prescale switches, so a switch may capture early
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ps_q <= 4'h0;
    end else if (!cap_mode) begin
      ps_q <= 4'h0;
    end else if (rise) begin
      ps_q <= ps_q + 4'h1;
    end
  end

  // ==========================================================
  // first timer and compare
  // ==========================================================
  wire match = cmp_mode & (tmr_q == res_q);
  reg match_prev_q;
  wire match_evt = match & ~match_prev_q;
  wire spec_evt = match_evt & spec_mode;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tmr_q <= {TW{1'b0}};
      tmr_on_q <= 1'b0;
      match_prev_q <= 1'b0;
    end else begin
      match_prev_q <= match;
      if (wr_tctl) begin
        tmr_on_q <= wd[0];
      end
      if (spec_evt) begin
        tmr_q <= {TW{1'b0}};
      end else if (wr_tmrl) begin
        tmr_q[7:0] <= wd;
      end else if (wr_tmrh) begin
        tmr_q[TW-1:8] <= wd[TW-9:0];
      end else if (tmr_on_q) begin
        tmr_q <= tmr_q + {{(TW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==========================================================
  // registers
  // ==========================================================
  wire cap_evt = cap_mode & evt;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= `ECM_MODE_RST;
      tris_q <= `ECM_TRIS_RST;
      res_q <= {TW{1'b0}};
      mask_q <= 8'h00;
      pin_data_q <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_q <= wd & `ECM_MODE_WMASK;
      end
      if (wr_tris) begin
        tris_q <= wd;
      end
      if (wr_mask) begin
        mask_q <= wd & `ECM_STAT_WMASK;
      end
      if (wr_pin) begin
        pin_data_q <= wd[0];
      end
      // capture beats a same-cycle software write and overwrites unread data
      if (cap_evt) begin
        res_q <= tmr_q;
      end else begin
        if (wr_resl) begin
          res_q[7:0] <= wd;
        end
        if (wr_resh) begin
          res_q[TW-1:8] <= wd[TW-9:0];
        end
      end
    end
  end

  // ==========================================================
  // flags and interrupt
  // ==========================================================
  // set wins over write-one-to-clear; hardware never clears
  wire [7:0] stat_set = {6'h00, spec_evt, cap_evt | match_evt};
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= 8'h00;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? wd : 8'h00)) | stat_set;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
      adc_start <= 1'b0;
      capture_pin_out <= 1'b0;
      capture_pin_oe <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
      adc_start <= spec_evt & adc_enabled;
      capture_pin_out <= pin_data_q;
      capture_pin_oe <= pin_drv;
    end
  end

  // ==========================================================
  // read path
  // ==========================================================
  // bits 5:4 are stored but steer nothing here: duty LSbs for pwm only
  reg [7:0] rd;
  always @* begin
    case (idx)
      `ECM_IDX_MODE: rd = mode_q;
      `ECM_IDX_TRIS: rd = tris_q;
      `ECM_IDX_RESL: rd = res_q[7:0];
      `ECM_IDX_RESH: rd = res_q[TW-1:8];
      `ECM_IDX_TMRL: rd = tmr_q[7:0];
      `ECM_IDX_TMRH: rd = tmr_q[TW-1:8];
      `ECM_IDX_TCTL: rd = {7'h00, tmr_on_q};
      `ECM_IDX_STAT: rd = stat_q;
      `ECM_IDX_MASK: rd = mask_q;
      `ECM_IDX_PIN: rd = {6'h00, pin_level, pin_data_q};
      default: rd = 8'h00;
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= req;
      avs_waitrequest <= ~req;
      avs_readdata <= (avs_read & req) ? {24'h000000, rd} : 32'h00000000;
    end
  end

endmodule // ecm_capture_unit

// ### ecm_capture_unit_properties.sv
`timescale 1ns/1ps
// ====
// bus, pin and conversion-start checks
module ecm_capture_unit_properties (
  input wire clk_sys,
  input wire arst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire capture_pin_out,
  input wire capture_pin_oe,
  input wire adc_enabled,
  input wire adc_start
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_wdone(idx);
    avs_write && !avs_waitrequest && avs_address[9:2] == idx;
  endsequence
  a_wait_answer: assert property (s_req |=> !avs_waitrequest)
    else $error("no answer");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  a_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  a_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_adc_pulse: assert property (adc_start |=> !adc_start)
    else $error("start pulse too long");
  a_adc_gate: assert property (adc_start |-> adc_enabled || $past(adc_enabled))
    else $error("start while converter off");
  a_oe_follow: assert property (s_wdone(8'h87) |=> capture_pin_oe == !$past(avs_writedata[2]))
    else $error("pin enable wrong");
  a_pin_follow: assert property (s_wdone(8'h25) |=> capture_pin_out == $past(avs_writedata[0]))
    else $error("pin data wrong");
endmodule // ecm_capture_unit_properties
bind ecm_capture_unit ecm_capture_unit_properties u_props (.clk_sys(clk_sys), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .capture_pin_out(capture_pin_out),
  .capture_pin_oe(capture_pin_oe), .adc_enabled(adc_enabled), .adc_start(adc_start));

// ### ecm_consts.vh
`ifndef ECM_CONSTS_VH
`define ECM_CONSTS_VH
// register indices (byte address = index * 4)
`define ECM_IDX_MODE 8'h17
`define ECM_IDX_TRIS 8'h87
`define ECM_IDX_RESL 8'h15
`define ECM_IDX_RESH 8'h16
`define ECM_IDX_TMRL 8'h20
`define ECM_IDX_TMRH 8'h21
`define ECM_IDX_TCTL 8'h22
`define ECM_IDX_STAT 8'h23
`define ECM_IDX_MASK 8'h24
`define ECM_IDX_PIN 8'h25
// mode field encodings
`define ECM_MODE_OFF 4'h0
`define ECM_MODE_CAP_FALL 4'h4
`define ECM_MODE_CAP_RISE 4'h5
`define ECM_MODE_CAP_4 4'h6
`define ECM_MODE_CAP_16 4'h7
`define ECM_MODE_CMP_SWI 4'hA
`define ECM_MODE_CMP_SPEC 4'hB
// field positions and reset values
`define ECM_TRIS_PIN_BIT 2
`define ECM_TRIS_RST 8'hFF
`define ECM_MODE_RST 8'h00
`define ECM_MODE_WMASK 8'h3F
`define ECM_STAT_EVT_BIT 0
`define ECM_STAT_SPEC_BIT 1
`define ECM_STAT_WMASK 8'h03
`define ECM_PS_MAX4 4'h3
`define ECM_PS_MAX16 4'hF
`endif

// ### ecm_pin_source.sv
`timescale 1ns/1ps
// ====
// far-side source on the capture pin
module ecm_pin_source (
  input wire lvl,
  input wire pin_out,
  input wire pin_oe,
  output wire pin
);
  // a driven pin loops back, so a data write can act as an edge
  assign pin = pin_oe ? pin_out : lvl;
endmodule // ecm_pin_source

// ### test_ecm_capture_unit.sv
`timescale 1ns/1ps
// ====
// bench top
module test_ecm_capture_unit;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic [9:0] avs_address = 10'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, pin_lvl = 1'h0, adc_enabled = 1'h1;
  logic capture_pin_in, capture_pin_out, capture_pin_oe, adc_start, irq;
  logic [7:0] exp_q[$];
  logic [15:0] tv;
  int n_fail = 0, checks_done = 0, cyc = 0, m, k, n;
  ecm_capture_unit dut (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .capture_pin_in(capture_pin_in), .capture_pin_out(capture_pin_out),
    .capture_pin_oe(capture_pin_oe), .adc_enabled(adc_enabled), .adc_start(adc_start),
    .irq(irq));
  ecm_pin_source u_src (.lvl(pin_lvl), .pin_out(capture_pin_out), .pin_oe(capture_pin_oe),
    .pin(capture_pin_in));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task check(input string what, input logic [7:0] seen, input logic [7:0] e);
    checks_done++;
    if (seen !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, seen);
    end
  endtask
  task complete_run;
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0) @(posedge clk_sys);
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk_sys);
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'h1, idx, d);
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'h0, idx, 8'h0);
  endtask
  task pulse;
    pin_lvl <= 1'h1;
    repeat (4) @(posedge clk_sys);
    pin_lvl <= 1'h0;
    repeat (4) @(posedge clk_sys);
  endtask
  // ====
  // result checker and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run;
    end
    if (avs_read && avs_waitrequest === 1'h0) check("rdata", avs_readdata[7:0], exp_q.pop_front());
  end
  // ====
  // scenarios
  initial begin
    tv = $urandom(32'h989a6ab6);
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'h1;
    rd(8'h87, 8'hFF);
    rd(8'h50, 8'h00);
    wr(8'h24, 8'h01);
    for (m = 4; m < 8; m++) begin
      n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
      tv = $urandom;
      wr(8'h17, 8'h00);
      wr(8'h23, 8'h03);
      wr(8'h20, tv[7:0]);
      wr(8'h21, tv[15:8]);
      wr(8'h17, m[7:0]);
      for (k = 1; k < n; k++) pulse;
      rd(8'h23, 8'h00);
      pulse;
      rd(8'h15, tv[7:0]);
      rd(8'h16, tv[15:8]);
      rd(8'h23, 8'h01);
      check("irq", {7'h0, irq}, 8'h01);
    end
    wr(8'h23, 8'h01);
    rd(8'h23, 8'h00);
    wr(8'h17, 8'h00);
    pulse;
    rd(8'h23, 8'h00);
    wr(8'h87, 8'hFB);
    wr(8'h17, 8'h05);
    wr(8'h25, 8'h01);
    // loopback plus two sync stages before the edge is seen
    repeat (4) @(posedge clk_sys);
    rd(8'h23, 8'h01);
    wr(8'h87, 8'hFF);
    wr(8'h17, 8'h00);
    wr(8'h23, 8'h03);
    wr(8'h15, 8'h10);
    rd(8'h15, 8'h10);
    wr(8'h16, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h00);
    wr(8'h17, 8'h0A);
    wr(8'h22, 8'h01);
    repeat (30) @(posedge clk_sys);
    rd(8'h23, 8'h01);
    check("pin", {7'h0, capture_pin_out}, 8'h01);
    wr(8'h20, 8'h00);
    wr(8'h17, 8'h0B);
    wr(8'h23, 8'h03);
    repeat (40) @(posedge clk_sys);
    rd(8'h23, 8'h03);
    complete_run;
  end
endmodule // test_ecm_capture_unit
